// >>> hdl/lpd_pkg.sv
// Constants, field layouts and helper functions for the panel driver.
package lpd_pkg;

    // ==========================================================================
    // Display memory routing
    // ==========================================================================
    localparam logic [7:0] LPD_BANK_DISPLAY = 8'h01;
    localparam logic [7:0] LPD_MEM_BASE     = 8'h40;
    localparam int         LPD_MEM_BYTES    = 112;
    localparam int         LPD_IDX_W        = 7;
    localparam int         LPD_COLS         = 56;
    localparam int         LPD_COMS         = 16;
    localparam int         LPD_LOGIC_COLS   = 24;

    // ==========================================================================
    // Control register fields
    // ==========================================================================
    localparam int LPD_LCD_EN_BIT      = 0;
    localparam int LPD_LCD_TYPE_BIT    = 1;
    localparam int LPD_LCD_RSEL_LO_BIT = 2;
    localparam int LPD_LCD_RSEL_HI_BIT = 3;
    localparam int LPD_DUTY_LSB        = 4;
    localparam int LPD_LED_EN_BIT      = 0;
    localparam int LPD_LED_SEL_BIT     = 1;
    localparam int LPD_LED_COM_HI_BIT  = 2;
    localparam int LPD_LED_SEG_HI_BIT  = 3;
    localparam int LPD_FUNC_GRP0_BIT   = 0;
    localparam int LPD_FUNC_GRP1_BIT   = 1;

    // Duty field codes.
    localparam logic [2:0] LPD_DUTY_STATIC = 3'h0;
    localparam logic [2:0] LPD_DUTY_HALF   = 3'h1;
    localparam logic [2:0] LPD_DUTY_THIRD  = 3'h2;
    localparam logic [2:0] LPD_DUTY_4      = 3'h3;
    localparam logic [2:0] LPD_DUTY_8      = 3'h4;
    localparam logic [2:0] LPD_DUTY_12     = 3'h5;
    localparam logic [2:0] LPD_DUTY_16     = 3'h6;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int         LPD_SUB_HZ          = 32768;
    localparam int         LPD_SUB_DIV         = 8;
    localparam int         LPD_DISP_HZ         = LPD_SUB_HZ / LPD_SUB_DIV;
    localparam int         LPD_FRAME_HZ        = 64;
    localparam int         LPD_TICKS_PER_FRAME = LPD_DISP_HZ / LPD_FRAME_HZ;
    localparam logic [2:0] LPD_DIV_LAST        = 3'(LPD_SUB_DIV - 1);
    localparam logic [2:0] LPD_DIV_RESET       = 3'h0;
    localparam logic [6:0] LPD_TICK_RESET      = 7'h00;
    localparam logic [3:0] LPD_SLOT_RESET      = 4'h0;

    // Number of backplane time slots for a duty code.
    function automatic logic [4:0] lpd_slots(input logic [2:0] duty);
        logic [4:0] n;
        unique case (duty)
            LPD_DUTY_STATIC: n = 5'h01;
            LPD_DUTY_HALF:   n = 5'h02;
            LPD_DUTY_THIRD:  n = 5'h03;
            LPD_DUTY_4:      n = 5'h04;
            LPD_DUTY_8:      n = 5'h08;
            LPD_DUTY_12:     n = 5'h0c;
            default:         n = 5'h10;
        endcase
        return n;
    endfunction

    // Display ticks per slot, chosen so every duty lands in 55..75 Hz frames.
    function automatic logic [6:0] lpd_slot_ticks(input logic [2:0] duty);
        return 7'(LPD_TICKS_PER_FRAME / int'(lpd_slots(duty)));
    endfunction

endpackage

// >>> hdl/lpd_display_ram.sv
// Display memory in flip-flops with software port and scan read taps.
`timescale 1ns/10ps
module lpd_display_ram
    import lpd_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  wr_en,
    input  wire logic [LPD_IDX_W-1:0]  wr_index,
    input  wire logic [7:0]            wr_data,
    input  wire logic [LPD_IDX_W-1:0]  rd_index,
    output logic      [7:0]            rd_data,
    input  wire logic [3:0]            slot,
    output logic      [LPD_COLS-1:0]   slot_pixels,
    output logic      [LPD_LOGIC_COLS-1:0] logic_levels
);

    // ==========================================================================
    // Storage
    // ==========================================================================
    // Column c keeps backplanes 0..7 in byte 2c and 8..15 in byte 2c+1.
    logic [7:0] mem      [LPD_MEM_BYTES];
    logic [7:0] next_mem [LPD_MEM_BYTES];

    always_comb begin
        next_mem = mem;
        if (wr_en) begin
            next_mem[wr_index] = wr_data;
        end
    end

    always_ff @(posedge clock) begin
        mem <= next_mem;
    end

    // ==========================================================================
    // Read taps
    // ==========================================================================
    always_comb begin
        rd_data = (int'(rd_index) < LPD_MEM_BYTES) ? mem[rd_index] : 8'h00;
        for (int c = 0; c < LPD_COLS; c++) begin
            slot_pixels[c] = mem[2 * c + int'(slot[3])][slot[2:0]];
        end
        for (int c = 0; c < LPD_LOGIC_COLS; c++) begin
            logic_levels[c] = mem[2 * c][0];
        end
    end

endmodule // lpd_display_ram

// >>> hdl/lpd_panel_driver.sv
// Top of the LCD/LED panel driver: routing, clocking, scan and line drive.
//
// Behaviour
// - Scan display memory continuously; written data appears on the panel unaided.
// - Bank one plus indirect pointer one from 0x40 reaches display memory.
// - Direct access to that range goes to bank zero general memory instead.
// - Enables light the display only when not asleep; sleep forces it off.
// - Two bias resistor select bits choose the internal bias resistor value.
// - Waveform type bit picks type A or type B drive scheme.
// - Two function registers pick column driver or logic output, columns 0-23.
// - A logic-output column drives the level held in display memory.
// - Columns 0-7 and 8-15 switch function as groups under one bit each.
// - Columns 16-23 each have their own function bit.
// - Display reset is active high: asleep or enable clear asserts it.
// - Display clock is the sub-clock divided by eight, giving 4 kHz.
// - Sub-clock source is picked by a fixed strap, not by software.
// - Kind select low gives LCD drive, high gives push-pull LED drive.
// - LED polarity bits set line activity; off display shows inactive levels.
// - LED duties static, 1/4, 1/8, 1/12, 1/16, frames 55 to 75 Hz.
`timescale 1ns/10ps
module lpd_panel_driver
    import lpd_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst_b,
    // Data memory access from the core.
    input  wire logic [7:0]                bank_pointer,
    input  wire logic                      mem_indirect,
    input  wire logic [7:0]                mem_addr,
    input  wire logic                      mem_wr,
    input  wire logic [7:0]                mem_wdata,
    output logic                           display_mem_hit,
    output logic                           general_mem_select,
    output logic      [7:0]                display_rdata,
    // Control registers and operating mode.
    input  wire logic [7:0]                liquid_crystal_control_reg,
    input  wire logic [7:0]                light_emitter_control_reg,
    input  wire logic [7:0]                column_function_reg_a,
    input  wire logic [7:0]                column_function_reg_b,
    input  wire logic                      sleep_mode,
    // Sub-clock sources and the fixed source strap.
    input  wire logic                      internal_low_speed_osc,
    input  wire logic                      external_crystal_osc,
    input  wire logic                      sub_clock_source_strap,
    // Panel side.
    output logic      [LPD_COMS-1:0]       backplane_line,
    output logic      [LPD_COLS-1:0]       display_column_line,
    output logic      [LPD_LOGIC_COLS-1:0] column_logic_mode,
    output logic                           drive_is_led,
    output logic                           lcd_drive_phase,
    output logic      [1:0]                bias_resistor_select,
    output logic                           display_reset
);

    // ==========================================================================
    // Memory routing
    // ==========================================================================
    logic [7:0]                offset;
    logic                      in_range;
    logic [LPD_IDX_W-1:0]      mem_index;
    logic [LPD_COLS-1:0]       slot_pixels;
    logic [LPD_LOGIC_COLS-1:0] logic_levels;
    logic [3:0]                slot;
    logic [3:0]                next_slot;

    always_comb begin
        offset             = mem_addr - LPD_MEM_BASE;
        in_range           = (mem_addr >= LPD_MEM_BASE) && (int'(offset) < LPD_MEM_BYTES);
        mem_index          = in_range ? offset[LPD_IDX_W-1:0] : {LPD_IDX_W{1'b1}};
        display_mem_hit    = in_range && mem_indirect
                             && (bank_pointer == LPD_BANK_DISPLAY);
        general_mem_select = !display_mem_hit;
    end

    lpd_display_ram u_ram (
        .clock        (clock),
        .wr_en        (display_mem_hit && mem_wr),
        .wr_index     (mem_index),
        .wr_data      (mem_wdata),
        .rd_index     (mem_index),
        .rd_data      (display_rdata),
        .slot         (next_slot),
        .slot_pixels  (slot_pixels),
        .logic_levels (logic_levels)
    );

    // ==========================================================================
    // Control decode
    // ==========================================================================
    logic       lcd_en;
    logic       led_en;
    logic       led_mode;
    logic       type_b;
    logic       com_hi;
    logic       seg_hi;
    logic [2:0] duty;
    logic       disp_on;

    always_comb begin
        lcd_en   = liquid_crystal_control_reg[LPD_LCD_EN_BIT];
        led_en   = light_emitter_control_reg[LPD_LED_EN_BIT];
        led_mode = light_emitter_control_reg[LPD_LED_SEL_BIT];
        type_b   = liquid_crystal_control_reg[LPD_LCD_TYPE_BIT];
        com_hi   = light_emitter_control_reg[LPD_LED_COM_HI_BIT];
        seg_hi   = light_emitter_control_reg[LPD_LED_SEG_HI_BIT];
        // LED mode accepts only its own duty set; other codes fall to 1/16.
        duty     = led_mode ? light_emitter_control_reg[LPD_DUTY_LSB +: 3]
                            : liquid_crystal_control_reg[LPD_DUTY_LSB +: 3];
        if (led_mode && (duty == LPD_DUTY_HALF || duty == LPD_DUTY_THIRD)) begin
            duty = LPD_DUTY_16;
        end
        // Sleep overrides both enables; the driver restarts cleanly on wake.
        display_reset = sleep_mode || !lcd_en;
        disp_on       = !display_reset && (!led_mode || led_en);
    end

    // ==========================================================================
    // Sub-clock capture and divide by eight
    // ==========================================================================
    logic [1:0] int_sync;
    logic [1:0] ext_sync;
    logic [1:0] strap_sync;
    logic       sub_prev;
    logic [2:0] div_cnt;
    logic       sub_level;
    logic       sub_rise;
    logic       disp_tick;
    logic [1:0] next_int_sync;
    logic [1:0] next_ext_sync;
    logic [1:0] next_strap_sync;
    logic [2:0] next_div_cnt;

    always_comb begin
        next_int_sync   = {int_sync[0], internal_low_speed_osc};
        next_ext_sync   = {ext_sync[0], external_crystal_osc};
        next_strap_sync = {strap_sync[0], sub_clock_source_strap};
        sub_level       = strap_sync[1] ? ext_sync[1] : int_sync[1];
        sub_rise        = sub_level && !sub_prev;
        disp_tick       = sub_rise && (div_cnt == LPD_DIV_LAST);
        next_div_cnt    = div_cnt;
        if (sub_rise) begin
            next_div_cnt = div_cnt + 3'h1;
        end
    end

    always_ff @(posedge clock) begin
        int_sync   <= next_int_sync;
        ext_sync   <= next_ext_sync;
        strap_sync <= next_strap_sync;
        sub_prev   <= sub_level;
        if (!rst_b) begin
            div_cnt <= LPD_DIV_RESET;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // ==========================================================================
    // Slot scan
    // ==========================================================================
    logic [6:0]          tick_cnt;
    logic [6:0]          next_tick_cnt;
    logic                phase;
    logic                next_phase;
    logic                slot_start;
    logic [LPD_COLS-1:0] col_latch;
    logic [LPD_COLS-1:0] next_col_latch;

    always_comb begin
        next_tick_cnt  = tick_cnt;
        next_slot      = slot;
        next_phase     = phase;
        slot_start     = 1'b0;
        if (display_reset) begin
            next_tick_cnt = LPD_TICK_RESET;
            next_slot     = LPD_SLOT_RESET;
            next_phase    = 1'b0;
        end else if (disp_tick) begin
            if (!type_b) begin
                next_phase = !phase;
            end
            if (tick_cnt == lpd_slot_ticks(duty) - 7'h01) begin
                next_tick_cnt = LPD_TICK_RESET;
                slot_start    = 1'b1;
                if ({1'b0, slot} >= lpd_slots(duty) - 5'h01) begin
                    next_slot = LPD_SLOT_RESET;
                    if (type_b) begin
                        next_phase = !phase;
                    end
                end else begin
                    next_slot = slot + 4'h1;
                end
            end else begin
                next_tick_cnt = tick_cnt + 7'h01;
            end
        end
        // Pixels are captured only at a slot boundary or during display reset so a write never tears a slot.
        next_col_latch = (slot_start || display_reset) ? slot_pixels : col_latch;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tick_cnt  <= LPD_TICK_RESET;
            slot      <= LPD_SLOT_RESET;
            phase     <= 1'b0;
            col_latch <= '0;
        end else begin
            tick_cnt  <= next_tick_cnt;
            slot      <= next_slot;
            phase     <= next_phase;
            col_latch <= next_col_latch;
        end
    end

    // ==========================================================================
    // Line drive
    // ==========================================================================
    logic [LPD_COMS-1:0]       next_backplane;
    logic [LPD_COLS-1:0]       next_column;
    logic [LPD_LOGIC_COLS-1:0] next_logic_mode;
    logic [LPD_COMS-1:0]       com_sel;

    always_comb begin
        next_logic_mode = {column_function_reg_b,
                           {8{column_function_reg_a[LPD_FUNC_GRP1_BIT]}},
                           {8{column_function_reg_a[LPD_FUNC_GRP0_BIT]}}};
        com_sel = '0;
        for (int k = 0; k < LPD_COMS; k++) begin
            com_sel[k] = (k == int'(slot)) || (duty == LPD_DUTY_STATIC);
        end
        if (led_mode) begin
            next_backplane = disp_on ? (com_hi ? com_sel : ~com_sel)
                                     : {LPD_COMS{!com_hi}};
            next_column    = disp_on ? (seg_hi ? col_latch : ~col_latch)
                                     : {LPD_COLS{!seg_hi}};
        end else begin
            // LCD lines carry select and phase only; the analog level stage
            // turns them into bias voltages.
            next_backplane = disp_on ? (com_sel ^ {LPD_COMS{phase}}) : '0;
            next_column    = disp_on ? (col_latch ^ {LPD_COLS{phase}}) : '0;
        end
        for (int c = 0; c < LPD_LOGIC_COLS; c++) begin
            if (next_logic_mode[c]) begin
                next_column[c] = logic_levels[c];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            backplane_line       <= '0;
            display_column_line  <= '0;
            column_logic_mode    <= '0;
            drive_is_led         <= 1'b0;
            lcd_drive_phase      <= 1'b0;
            bias_resistor_select <= 2'h0;
        end else begin
            backplane_line       <= next_backplane;
            display_column_line  <= next_column;
            column_logic_mode    <= next_logic_mode;
            drive_is_led         <= led_mode;
            lcd_drive_phase      <= phase;
            bias_resistor_select <= {liquid_crystal_control_reg[LPD_LCD_RSEL_HI_BIT],
                                     liquid_crystal_control_reg[LPD_LCD_RSEL_LO_BIT]};
        end
    end

endmodule // lpd_panel_driver

// >>> testbench/lpd_panel_driver_asserts.sv
// Port-level assertions for the panel driver, bound into its top module.
`timescale 1ns/10ps
module lpd_panel_driver_asserts
    import lpd_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      rst_b,
    input wire logic [7:0]                bank_pointer,
    input wire logic                      mem_indirect,
    input wire logic [7:0]                mem_addr,
    input wire logic                      display_mem_hit,
    input wire logic                      general_mem_select,
    input wire logic [7:0]                display_rdata,
    input wire logic [7:0]                liquid_crystal_control_reg,
    input wire logic [7:0]                light_emitter_control_reg,
    input wire logic [7:0]                column_function_reg_a,
    input wire logic [7:0]                column_function_reg_b,
    input wire logic                      sleep_mode,
    input wire logic [LPD_COMS-1:0]       backplane_line,
    input wire logic [LPD_LOGIC_COLS-1:0] column_logic_mode,
    input wire logic                      drive_is_led,
    input wire logic                      lcd_drive_phase,
    input wire logic [1:0]                bias_resistor_select,
    input wire logic                      display_reset
);
    // ==========================================================================
    // Helpers
    // ==========================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Registered outputs are zero for a couple of edges after reset, so the
    // one-cycle relations wait until this counter has run.
    logic [1:0] run_cnt;
    logic [1:0] next_run_cnt;
    logic [7:0] lcr;
    logic [7:0] ler;
    assign lcr = liquid_crystal_control_reg;
    assign ler = light_emitter_control_reg;
    always_comb begin
        next_run_cnt = (run_cnt == 2'h3) ? run_cnt : run_cnt + 2'h1;
    end
    always_ff @(posedge clock) begin
        run_cnt <= rst_b ? next_run_cnt : 2'h0;
    end
    // ==========================================================================
    // Properties
    // ==========================================================================
    property p_reset_fn;
        display_reset == (sleep_mode || !lcr[LPD_LCD_EN_BIT]);
    endproperty
    a_reset_fn: assert property (p_reset_fn) else $error("display reset wrong");
    property p_hit;
        display_mem_hit == (bank_pointer == LPD_BANK_DISPLAY && mem_indirect
            && mem_addr >= LPD_MEM_BASE && mem_addr <= 8'haf);
    endproperty
    a_hit: assert property (p_hit) else $error("display routing wrong");
    property p_general;
        general_mem_select != display_mem_hit;
    endproperty
    a_general: assert property (p_general) else $error("general select wrong");
    property p_rdata_out;
        (mem_addr < LPD_MEM_BASE || mem_addr > 8'haf) |-> display_rdata == 8'h00;
    endproperty
    a_rdata_out: assert property (p_rdata_out) else $error("read outside area");
    property p_bias;
        run_cnt[1] |-> bias_resistor_select == $past({lcr[3], lcr[2]});
    endproperty
    a_bias: assert property (p_bias) else $error("bias select wrong");
    property p_kind;
        run_cnt[1] |-> drive_is_led == $past(ler[LPD_LED_SEL_BIT]);
    endproperty
    a_kind: assert property (p_kind) else $error("panel kind wrong");
    property p_func;
        run_cnt[1] |-> column_logic_mode == $past({column_function_reg_b,
            {8{column_function_reg_a[1]}}, {8{column_function_reg_a[0]}}});
    endproperty
    a_func: assert property (p_func) else $error("column function wrong");
    property p_off_lines;
        (run_cnt[1] && display_reset && $stable(ler))[*3] |->
            backplane_line == (ler[1] ? {LPD_COMS{~ler[2]}} : '0);
    endproperty
    a_off_lines: assert property (p_off_lines) else $error("off lines wrong");
    property p_phase_rst;
        (run_cnt[1] && display_reset)[*3] |-> !lcd_drive_phase;
    endproperty
    a_phase_rst: assert property (p_phase_rst) else $error("phase in reset");
    c_led: cover property (drive_is_led && !display_reset);
    c_hit: cover property (display_mem_hit);
    c_logic: cover property (column_logic_mode != '0);
    c_phase: cover property ($rose(lcd_drive_phase));
endmodule // lpd_panel_driver_asserts

bind lpd_panel_driver lpd_panel_driver_asserts u_chk (
    .clock(clock), .rst_b(rst_b), .bank_pointer(bank_pointer),
    .mem_indirect(mem_indirect), .mem_addr(mem_addr),
    .display_mem_hit(display_mem_hit), .general_mem_select(general_mem_select),
    .display_rdata(display_rdata), .sleep_mode(sleep_mode),
    .liquid_crystal_control_reg(liquid_crystal_control_reg),
    .light_emitter_control_reg(light_emitter_control_reg),
    .column_function_reg_a(column_function_reg_a),
    .column_function_reg_b(column_function_reg_b),
    .backplane_line(backplane_line), .column_logic_mode(column_logic_mode),
    .drive_is_led(drive_is_led), .lcd_drive_phase(lcd_drive_phase),
    .bias_resistor_select(bias_resistor_select), .display_reset(display_reset)
);

// >>> testbench/lpd_osc_model.sv
// Sub-clock oscillators standing outside the driver.
`timescale 1ns/10ps
module lpd_osc_model (
    output logic internal_low_speed_osc,
    output logic external_crystal_osc
);
    // Both run far above 32768 Hz to keep waits short; the bench measures the
    // divide ratio, which does not depend on the absolute rate.
    initial begin
        internal_low_speed_osc = 1'b0;
        #3;
        forever #64 internal_low_speed_osc = ~internal_low_speed_osc;
    end
    initial begin
        external_crystal_osc = 1'b0;
        #5;
        forever #96 external_crystal_osc = ~external_crystal_osc;
    end
endmodule // lpd_osc_model

// >>> testbench/lpd_panel_driver_tb.sv
// Self-checking bench for the panel driver.
`timescale 1ns/10ps
module lpd_panel_driver_tb;
    import lpd_pkg::*;
    logic        clock, rst_b, mem_indirect, mem_wr, sleep_mode, strap;
    logic [7:0]  bank, addr, wdata, lcr, ler, cfa, cfb, rdata, d;
    logic        hit, gsel, is_led, phase, drst, osc_i, osc_e, h;
    logic [15:0] bp;
    logic [55:0] col;
    logic [23:0] lmode;
    logic [1:0]  bias;
    int          err_total, total_checks, n;
    lpd_osc_model u_osc (.internal_low_speed_osc(osc_i), .external_crystal_osc(osc_e));
    lpd_panel_driver u_dut (.clock(clock), .rst_b(rst_b), .bank_pointer(bank),
        .mem_indirect(mem_indirect), .mem_addr(addr), .mem_wr(mem_wr), .mem_wdata(wdata),
        .display_mem_hit(hit), .general_mem_select(gsel), .display_rdata(rdata),
        .liquid_crystal_control_reg(lcr), .light_emitter_control_reg(ler),
        .column_function_reg_a(cfa), .column_function_reg_b(cfb), .sleep_mode(sleep_mode),
        .internal_low_speed_osc(osc_i), .external_crystal_osc(osc_e),
        .sub_clock_source_strap(strap), .backplane_line(bp), .display_column_line(col),
        .column_logic_mode(lmode), .drive_is_led(is_led), .lcd_drive_phase(phase),
        .bias_resistor_select(bias), .display_reset(drst));
    // ==========================================================================
    // Shared tasks
    // ==========================================================================
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_n(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            err_total++;
            $display("[ERR] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] b, input logic i, input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        {bank, mem_indirect, addr, wdata, mem_wr} = {b, i, a, v, 1'b1};
        @(negedge clock);
        mem_wr = 1'b0;
    endtask
    task automatic look(input logic [7:0] b, input logic i, input logic [7:0] a);
        @(negedge clock);
        {bank, mem_indirect, addr} = {b, i, a};
        #1;
        d = rdata;
        h = hit;
    endtask
    task automatic wait_phase(input int lim);
        logic was;
        n = 0;
        was = phase;
        while (phase === was && n < lim) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic wait_bp(input logic [15:0] v);
        n = 0;
        while (bp !== v && n < 12000) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask
    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic t_routing();
        wr(8'h01, 1'b1, 8'h40, 8'ha5);
        wr(8'h01, 1'b1, 8'haf, 8'h3c);
        wr(8'h01, 1'b0, 8'h40, 8'h11);
        wr(8'h00, 1'b1, 8'h40, 8'h22);
        look(8'h01, 1'b1, 8'h40);
        chk("byte 40", 8'ha5, d);
        look(8'h01, 1'b1, 8'haf);
        chk("byte af", 8'h3c, d);
        look(8'h01, 1'b0, 8'h40);
        chk("direct hit", 1'b0, h);
        chk("direct general", 1'b1, gsel);
        look(8'h00, 1'b1, 8'h40);
        chk("bank0 hit", 1'b0, h);
        look(8'h01, 1'b1, 8'hb0);
        chk("past end hit", 1'b0, h);
    endtask
    task automatic t_reset_fn();
        for (int k = 0; k < 4; k++) begin
            @(negedge clock);
            lcr[0] = k[0];
            sleep_mode = k[1] ^ k[0];
            #1;
            chk("display reset", k != 3, drst);
        end
    endtask
    task automatic t_ctrl();
        for (int b = 0; b < 4; b++) begin
            @(negedge clock);
            lcr[3:2] = b[1:0];
            settle();
            chk("bias", b[1:0], bias);
        end
        ler[1] = 1'b1;
        settle();
        chk("led kind", 1'b1, is_led);
        ler[1] = 1'b0;
    endtask
    task automatic t_phase();
        lcr = 8'h01;
        wait_phase(1000);
        wait_phase(1000);
        chk_n("type A step", 8 * 16, n);
        strap = 1'b1;
        repeat (2) wait_phase(1000);
        wait_phase(1000);
        chk_n("external step", 8 * 24, n);
        strap = 1'b0;
        lcr = 8'h03;
        repeat (2) wait_phase(10000);
        chk_n("type B step", 64 * 8 * 16, n);
    endtask
    task automatic t_led();
        lcr = 8'h00;
        ler = 8'h02;
        wr(8'h01, 1'b1, 8'h40, 8'h05);
        {ler, lcr} = {8'h37, 8'h01};
        wait_bp(16'h0002);
        chk("slot1 col", 1'b1, col[0]);
        wait_bp(16'h0004);
        chk_n("slot length", 16 * 8 * 16, n);
        chk("slot2 col", 1'b0, col[0]);
        sleep_mode = 1'b1;
        settle();
        chk("sleep com", 16'h0000, bp);
        chk("sleep seg", 1'b1, col[0]);
        sleep_mode = 1'b0;
        ler = 8'h00;
    endtask
    task automatic t_logic();
        cfa = 8'h01;
        cfb = 8'h01;
        wr(8'h01, 1'b1, 8'h40, 8'h01);
        wr(8'h01, 1'b1, 8'h42, 8'h00);
        wr(8'h01, 1'b1, 8'h60, 8'h01);
        settle();
        chk("logic mode", 24'h0100ff, lmode);
        chk("logic cols", 3'h5, {col[16], col[1], col[0]});
        wr(8'h01, 1'b1, 8'h40, 8'h00);
        settle();
        chk("logic col0", 1'b0, col[0]);
    endtask
    // ==========================================================================
    // Sequence
    // ==========================================================================
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (80000) @(posedge clock);
        err_total++;
        complete_run();
    end
    initial begin
        {err_total, total_checks} = 64'h0;
        {rst_b, mem_indirect, mem_wr, sleep_mode, strap} = 5'h00;
        {bank, addr, wdata, lcr, ler, cfa, cfb} = 56'h0;
        repeat (4) @(negedge clock);
        chk("reset lines", 16'h0000, bp);
        rst_b = 1'b1;
        t_routing();
        t_reset_fn();
        t_ctrl();
        t_phase();
        t_led();
        t_logic();
        complete_run();
    end
endmodule // lpd_panel_driver_tb
